/* File: rtl/liveness_pkg.sv */
// package: register map, field layout, defaults and timing for the liveness watchdog
`default_nettype none
package liveness_pkg;
  // ==================== clock and tick ====================
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned TICK_PERIOD_S = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
  // ==================== register offsets ====================
  localparam logic [11:0] GLOBAL_CTRL_OFS = 12'h000;
  localparam logic [11:0] IRQ_STATUS_OFS = 12'h004;
  localparam logic [11:0] IRQ_MASK_OFS = 12'h008;
  localparam logic [11:0] PORT_BASE_OFS = 12'h100;
  localparam logic [11:0] PORT_STRIDE = 12'h010;
  localparam logic [3:0] PORT_CFG_OFS = 4'h0;
  localparam logic [3:0] PORT_TIME_OFS = 4'h4;
  localparam logic [3:0] PORT_HOST_OFS = 4'h8;
  localparam logic [3:0] PORT_STAT_OFS = 4'hC;
  // ==================== port config field layout ====================
  localparam int unsigned CFG_EN_BIT = 0;
  localparam int unsigned CFG_ACT_LSB = 4;
  localparam int unsigned CFG_RETRY_LSB = 8;
  localparam int unsigned CFG_IVL_LSB = 16;
  localparam int unsigned TIME_OFF_LSB = 0;
  localparam int unsigned TIME_START_LSB = 16;
  // ==================== legal ranges and defaults (times in seconds, retry in probes) ====================
  localparam logic [9:0] OFF_DEF = 10'h00F;
  localparam logic [9:0] OFF_MIN = 10'h003;
  localparam logic [9:0] OFF_MAX = 10'h078;
  localparam logic [9:0] START_DEF = 10'h03C;
  localparam logic [9:0] START_MIN = 10'h01E;
  localparam logic [9:0] START_MAX = 10'h258;
  localparam logic [9:0] IVL_DEF = 10'h01E;
  localparam logic [9:0] IVL_MIN = 10'h00A;
  localparam logic [9:0] IVL_MAX = 10'h078;
  localparam logic [2:0] RETRY_DEF = 3'h2;
  localparam logic [2:0] RETRY_MIN = 3'h1;
  localparam logic [2:0] RETRY_MAX = 3'h5;
  localparam logic [31:0] HOST_DEF = 32'h00000000;
  // ==================== failure actions ====================
  typedef enum logic [1:0] {ACT_ALL, ACT_ALARM, ACT_NONE, ACT_REBOOT} action_t;
  // ==================== per-port settings carrier ====================
  typedef struct packed {
    logic enable;
    action_t action;
    logic [2:0] retry;
    logic [9:0] interval;
    logic [9:0] off_time;
    logic [9:0] start_time;
  } port_cfg_t;
  localparam port_cfg_t PORT_CFG_DEF = '{1'b0, ACT_ALL, RETRY_DEF, IVL_DEF, OFF_DEF, START_DEF};
  // probe request, alarm pulse and power level for one port
  typedef struct packed {
    logic probe;
    logic alarm;
    logic power_on;
  } port_out_t;
endpackage : liveness_pkg
`default_nettype wire

/* File: rtl/liveness_watchdog.sv */
// module: multi-port liveness watchdog with an AXI4-Lite register slave
`default_nettype none
module liveness_watchdog #(
  parameter int unsigned PORTS = 8, // number of supervised ports
  parameter int unsigned TICK_CYCLES = liveness_pkg::TICK_CYCLES // clocks per second
) (
  input wire logic clk_i, // 25 MHz system clock
  input wire logic rstn_i, // synchronous reset, active low
  input wire logic [11:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [11:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [PORTS-1:0] answer_i, // probe answer pulse per port
  output logic [PORTS-1:0] probe_o, // probe request pulse per port
  output logic [PORTS-1:0] power_on_o, // port power enable level
  output logic [PORTS-1:0] alarm_o, // administrator alarm pulse per port
  output logic irq_o // level interrupt
);
  localparam int TW = $clog2(TICK_CYCLES);

  // ==================== state ====================
  typedef struct packed {
    logic [TW-1:0] div;
    logic tick;
    logic global_en;
    logic [PORTS-1:0] irq_status;
    logic [PORTS-1:0] irq_mask;
    logic [PORTS-1:0][31:0] host;
    logic [PORTS-1:0][$bits(liveness_pkg::port_cfg_t)-1:0] cfg;
    logic aw_held;
    logic [11:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;
  state_t st_reg, st_next;

  liveness_pkg::port_out_t [PORTS-1:0] pout;
  logic [PORTS-1:0][2:0] misses;
  logic [PORTS-1:0][1:0] phase;

  // ==================== per-port engines ====================
  for (genvar p = 0; p < PORTS; p++) begin : g_port
    port_liveness u_port (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .tick_i(st_reg.tick),
      .global_en_i(st_reg.global_en),
      .cfg_i(liveness_pkg::port_cfg_t'(st_reg.cfg[p])),
      .answer_i(answer_i[p]),
      .out_o(pout[p]),
      .misses_o(misses[p]),
      .phase_o(phase[p])
    );
    assign probe_o[p] = pout[p].probe;
    assign alarm_o[p] = pout[p].alarm;
    assign power_on_o[p] = pout[p].power_on;
  end

  // ==================== register write with range checks ====================
  function automatic logic [9:0] clamp10(input logic [9:0] v, input logic [9:0] lo, input logic [9:0] hi,
                                         input logic [9:0] old);
    clamp10 = (v < lo || v > hi) ? old : v;
  endfunction : clamp10

  // divider, register file, axi handshakes
  always_comb begin
    liveness_pkg::port_cfg_t c;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] rd;
    int unsigned idx;
    c = liveness_pkg::PORT_CFG_DEF;
    a = 12'h000;
    d = 32'h00000000;
    rd = 32'h00000000;
    idx = 0;
    st_next = st_reg;
    // one-second tick
    st_next.tick = 1'b0;
    if (st_reg.div == TW'(TICK_CYCLES - 1)) begin
      st_next.div = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.div = st_reg.div + TW'(1);
    end
    // capture write address and data in either order
    if (s_axi_awvalid && !st_reg.aw_held) begin
      st_next.aw_held = 1'b1;
      st_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.w_held) begin
      st_next.w_held = 1'b1;
      st_next.wdata = s_axi_wdata;
      st_next.wstrb = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    // sticky events, set wins over a clearing read
    for (int p = 0; p < PORTS; p++) begin
      if (st_reg.rvalid == 1'b0 && s_axi_arvalid && s_axi_araddr == liveness_pkg::IRQ_STATUS_OFS) begin
        st_next.irq_status[p] = 1'b0;
      end
      if (pout[p].alarm) begin
        st_next.irq_status[p] = 1'b1;
      end
    end
    // perform a write once both halves are held
    if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid) begin
      a = st_reg.awaddr;
      d = st_reg.wdata;
      st_next.aw_held = 1'b0;
      st_next.w_held = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = 2'h0;
      if (st_reg.wstrb != 4'hF) begin
        st_next.bresp = 2'h2;
      end else if (a == liveness_pkg::GLOBAL_CTRL_OFS) begin
        st_next.global_en = d[0];
      end else if (a == liveness_pkg::IRQ_MASK_OFS) begin
        st_next.irq_mask = d[PORTS-1:0];
      end else if (a == liveness_pkg::IRQ_STATUS_OFS) begin
        st_next.bresp = 2'h0;
      end else if (a >= liveness_pkg::PORT_BASE_OFS && a < liveness_pkg::PORT_BASE_OFS + 12'(PORTS * 16)) begin
        idx = 32'((a - liveness_pkg::PORT_BASE_OFS) >> 4);
        c = liveness_pkg::port_cfg_t'(st_reg.cfg[idx]);
        case (a[3:0])
          liveness_pkg::PORT_CFG_OFS: begin
            c.enable = d[liveness_pkg::CFG_EN_BIT];
            c.action = liveness_pkg::action_t'(d[liveness_pkg::CFG_ACT_LSB +: 2]);
            if (d[liveness_pkg::CFG_RETRY_LSB +: 3] >= liveness_pkg::RETRY_MIN &&
                d[liveness_pkg::CFG_RETRY_LSB +: 3] <= liveness_pkg::RETRY_MAX) begin
              c.retry = d[liveness_pkg::CFG_RETRY_LSB +: 3];
            end
            c.interval = clamp10(d[liveness_pkg::CFG_IVL_LSB +: 10], liveness_pkg::IVL_MIN,
                                 liveness_pkg::IVL_MAX, c.interval);
          end
          liveness_pkg::PORT_TIME_OFS: begin
            c.off_time = clamp10(d[liveness_pkg::TIME_OFF_LSB +: 10], liveness_pkg::OFF_MIN,
                                 liveness_pkg::OFF_MAX, c.off_time);
            c.start_time = clamp10(d[liveness_pkg::TIME_START_LSB +: 10], liveness_pkg::START_MIN,
                                   liveness_pkg::START_MAX, c.start_time);
          end
          liveness_pkg::PORT_HOST_OFS: st_next.host[idx] = d;
          default: st_next.bresp = 2'h0;
        endcase
        st_next.cfg[idx] = c;
      end else begin
        st_next.bresp = 2'h2;
      end
    end
    // read path
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (!st_reg.rvalid && s_axi_arvalid) begin
      a = s_axi_araddr;
      st_next.rvalid = 1'b1;
      st_next.rresp = 2'h0;
      if (a == liveness_pkg::GLOBAL_CTRL_OFS) begin
        rd[0] = st_reg.global_en;
      end else if (a == liveness_pkg::IRQ_STATUS_OFS) begin
        rd[PORTS-1:0] = st_reg.irq_status;
      end else if (a == liveness_pkg::IRQ_MASK_OFS) begin
        rd[PORTS-1:0] = st_reg.irq_mask;
      end else if (a >= liveness_pkg::PORT_BASE_OFS && a < liveness_pkg::PORT_BASE_OFS + 12'(PORTS * 16)) begin
        idx = 32'((a - liveness_pkg::PORT_BASE_OFS) >> 4);
        c = liveness_pkg::port_cfg_t'(st_reg.cfg[idx]);
        case (a[3:0])
          liveness_pkg::PORT_CFG_OFS: begin
            rd[liveness_pkg::CFG_EN_BIT] = c.enable;
            rd[liveness_pkg::CFG_ACT_LSB +: 2] = c.action;
            rd[liveness_pkg::CFG_RETRY_LSB +: 3] = c.retry;
            rd[liveness_pkg::CFG_IVL_LSB +: 10] = c.interval;
          end
          liveness_pkg::PORT_TIME_OFS: begin
            rd[liveness_pkg::TIME_OFF_LSB +: 10] = c.off_time;
            rd[liveness_pkg::TIME_START_LSB +: 10] = c.start_time;
          end
          liveness_pkg::PORT_HOST_OFS: rd = st_reg.host[idx];
          liveness_pkg::PORT_STAT_OFS: begin
            rd[2:0] = misses[idx];
            rd[5:4] = phase[idx];
            rd[8] = pout[idx].power_on;
          end
          default: rd = 32'h00000000;
        endcase
      end else begin
        st_next.rresp = 2'h2;
      end
      st_next.rdata = rd;
    end
  end

  // state register with defaults
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st_reg <= '0;
      for (int p = 0; p < PORTS; p++) begin
        st_reg.cfg[p] <= liveness_pkg::PORT_CFG_DEF;
        st_reg.host[p] <= liveness_pkg::HOST_DEF;
      end
    end else begin
      st_reg <= st_next;
    end
  end

  // ==================== outputs ====================
  assign s_axi_awready = !st_reg.aw_held;
  assign s_axi_wready = !st_reg.w_held;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign irq_o = |(st_reg.irq_status & st_reg.irq_mask);
endmodule : liveness_watchdog
`default_nettype wire

/* File: rtl/port_liveness.sv */
// module: one port's probe timer, miss counter and power-cycle sequencer
`default_nettype none
module port_liveness (
  input wire logic clk_i, // system clock
  input wire logic rstn_i, // synchronous reset, active low
  input wire logic tick_i, // one-second enable pulse
  input wire logic global_en_i, // global check enable
  input wire liveness_pkg::port_cfg_t cfg_i, // port settings
  input wire logic answer_i, // probe answer pulse, synchronous
  output liveness_pkg::port_out_t out_o, // probe, alarm pulses and power level
  output logic [2:0] misses_o, // unanswered probes in a row
  output logic [1:0] phase_o // 0 run, 1 power off, 2 startup
);
  typedef enum logic [1:0] {PH_RUN, PH_OFF, PH_START} phase_t;
  typedef struct packed {
    phase_t phase;
    logic [9:0] secs;
    logic [2:0] misses;
    logic pending;
    liveness_pkg::port_out_t out;
  } state_t;
  state_t st_reg, st_next;

  // sequencing of probes, misses and actions
  always_comb begin
    st_next = st_reg;
    st_next.out.probe = 1'b0;
    st_next.out.alarm = 1'b0;
    if (answer_i && st_reg.pending) begin
      st_next.pending = 1'b0;
      st_next.misses = 3'h0;
    end
    case (st_reg.phase)
      PH_RUN: begin
        st_next.out.power_on = 1'b1;
        if (!global_en_i || !cfg_i.enable) begin
          st_next.secs = 10'h000;
          st_next.misses = 3'h0;
          st_next.pending = 1'b0;
        end else if (tick_i) begin
          if (st_reg.secs + 10'h001 >= cfg_i.interval) begin
            st_next.secs = 10'h000;
            st_next.out.probe = 1'b1;
            st_next.pending = 1'b1;
            if (st_reg.pending && !answer_i) begin
              if (st_reg.misses + 3'h1 > cfg_i.retry) begin
                st_next.misses = 3'h0;
                st_next.pending = 1'b0;
                st_next.out.probe = 1'b0;
                case (cfg_i.action)
                  liveness_pkg::ACT_ALL: begin
                    st_next.out.alarm = 1'b1;
                    st_next.out.power_on = 1'b0;
                    st_next.phase = PH_OFF;
                  end
                  liveness_pkg::ACT_ALARM: st_next.out.alarm = 1'b1;
                  liveness_pkg::ACT_REBOOT: begin
                    st_next.out.power_on = 1'b0;
                    st_next.phase = PH_OFF;
                  end
                  default: st_next.out.probe = 1'b1;
                endcase
              end else begin
                st_next.misses = st_reg.misses + 3'h1;
              end
            end
          end else begin
            st_next.secs = st_reg.secs + 10'h001;
          end
        end
      end
      PH_OFF: begin
        st_next.out.power_on = 1'b0;
        if (tick_i) begin
          if (st_reg.secs + 10'h001 >= cfg_i.off_time) begin
            st_next.secs = 10'h000;
            st_next.out.power_on = 1'b1;
            st_next.phase = PH_START;
          end else begin
            st_next.secs = st_reg.secs + 10'h001;
          end
        end
      end
      PH_START: begin
        st_next.out.power_on = 1'b1;
        if (tick_i) begin
          if (st_reg.secs + 10'h001 >= cfg_i.start_time) begin
            st_next.secs = 10'h000;
            st_next.phase = PH_RUN;
          end else begin
            st_next.secs = st_reg.secs + 10'h001;
          end
        end
      end
      default: st_next.phase = PH_RUN;
    endcase
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st_reg <= '{PH_RUN, 10'h000, 3'h0, 1'b0, 3'b001};
    end else begin
      st_reg <= st_next;
    end
  end

  assign out_o = st_reg.out;
  assign misses_o = st_reg.misses;
  assign phase_o = st_reg.phase;
endmodule : port_liveness
`default_nettype wire

/* File: verification/pd_farm.sv */
// partner: powered devices that answer probes promptly or late
`default_nettype none
module pd_farm #(
  parameter int unsigned PORTS = 2 // attached devices
) (
  input wire logic clk_i, // system clock
  input wire logic [PORTS-1:0] probe_i, // probe pulses
  input wire logic [PORTS-1:0] power_i, // port power
  input wire logic [PORTS-1:0] alive_i, // device running
  input wire logic [PORTS-1:0] slow_i, // answer late
  output logic [PORTS-1:0] answer_o // answer pulses
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] wait_cnt [PORTS] = '{default: 8'h00};
  // each probe starts a delay, short or long
  always_ff @(posedge clk_i) begin
    for (int p = 0; p < PORTS; p++) begin
      if (probe_i[p]) begin
        wait_cnt[p] <= slow_i[p] ? 8'h20 : 8'h01;
      end else if (wait_cnt[p] != 8'h00) begin
        wait_cnt[p] <= wait_cnt[p] - 8'h01;
      end
    end
  end
  // only a live, powered device answers
  always_comb begin
    for (int p = 0; p < PORTS; p++) begin
      answer_o[p] = alive_i[p] && power_i[p] && wait_cnt[p] == 8'h01;
    end
  end
endmodule : pd_farm
`default_nettype wire

/* File: verification/testbench.sv */
// testbench: bus-driven scenarios for the liveness watchdog
`default_nettype none
`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned NP = 2;
  localparam int unsigned TK = 10;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_o;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [NP-1:0] answer_i, probe_o, power_on_o, alarm_o;
  logic [NP-1:0] alive = 2'h3;
  logic [33:0] exp_q[$];
  int bad_count = 0;
  int total_checks = 0;
  int probe_cnt = 0, alarm_cnt = 0, fall_cnt = 0, off_cur = 0, off_len = 0;
  always #20 clk_i = ~clk_i;
  liveness_watchdog #(.PORTS(NP), .TICK_CYCLES(TK)) uut (.clk_i, .rstn_i, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .answer_i, .probe_o, .power_on_o, .alarm_o, .irq_o);
  pd_farm #(.PORTS(NP)) farm (.clk_i, .probe_i(probe_o), .power_i(power_on_o), .alive_i(alive),
    .slow_i(2'h2), .answer_o(answer_i));
  // monitor: bus answers against queued notes, port 0 events
  always @(negedge clk_i) begin
    if (s_axi_bvalid && s_axi_bready) `CHK({s_axi_bresp, 32'h00000000}, exp_q.pop_front())
    if (s_axi_rvalid && s_axi_rready) `CHK({s_axi_rresp, s_axi_rdata}, exp_q.pop_front())
    probe_cnt += probe_o[0];
    alarm_cnt += alarm_o[0];
    if (!power_on_o[0] && off_cur == 0) fall_cnt++;
    if (!power_on_o[0]) off_cur++;
    else if (off_cur != 0) begin
      off_len = off_cur;
      off_cur = 0;
    end
  end
  // one bus transfer; read data or write response noted first
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ah, wh, dh;
    exp_q.push_back({r, w ? 32'h00000000 : d});
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    do begin
      @(negedge clk_i);
      ah = (s_axi_awvalid && s_axi_awready) || (s_axi_arvalid && s_axi_arready);
      wh = s_axi_wvalid && s_axi_wready;
      dh = (s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready);
      @(posedge clk_i);
      if (ah) s_axi_awvalid <= 1'b0;
      if (ah) s_axi_arvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
    end while (!dh);
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task automatic secs(input int n);
    repeat (n * TK) @(posedge clk_i);
  endtask : secs
  function automatic logic [31:0] cfgw(input logic en, input logic [1:0] act, input logic [2:0] rt,
                                       input logic [9:0] iv);
    return {6'h00, iv, 5'h00, rt, 2'h0, act, 3'h0, en};
  endfunction : cfgw
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  // main sequence
  initial begin
    logic al, ct;
    logic [31:0] h;
    void'($urandom(18675));
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    for (int p = 0; p < NP; p++) begin
      bus(0, 12'h100 + 12'(16 * p), 32'h001E0200, 2'h0);
      bus(0, 12'h104 + 12'(16 * p), 32'h003C000F, 2'h0);
      bus(0, 12'h108 + 12'(16 * p), 32'h00000000, 2'h0);
      bus(0, 12'h10C + 12'(16 * p), 32'h00000100, 2'h0);
    end
    bus(0, 12'h120, 32'h00000000, 2'h2);
    bus(1, 12'h0F0, 32'h12345678, 2'h2);
    bus(1, 12'h100, cfgw(0, 2'h0, 3'h6, 10'h009), 2'h0);
    bus(0, 12'h100, 32'h001E0200, 2'h0);
    bus(1, 12'h100, cfgw(0, 2'h0, 3'h5, 10'h078), 2'h0);
    bus(0, 12'h100, 32'h00780500, 2'h0);
    bus(1, 12'h104, 32'h02590002, 2'h0);
    bus(0, 12'h104, 32'h003C000F, 2'h0);
    bus(1, 12'h104, 32'h001E0003, 2'h0);
    bus(0, 12'h104, 32'h001E0003, 2'h0);
    h = $urandom();
    bus(1, 12'h108, h, 2'h0);
    bus(0, 12'h108, h, 2'h0);
    // global enable clear: enabled ports stay silent
    bus(1, 12'h100, cfgw(1, 2'h2, 3'h1, 10'h00A), 2'h0);
    bus(1, 12'h110, cfgw(1, 2'h2, 3'h1, 10'h00A), 2'h0);
    // a partial-strobe write is refused and must not set the enable
    s_axi_wstrb <= 4'h3;
    bus(1, 12'h000, 32'h00000001, 2'h2);
    s_axi_wstrb <= 4'hF;
    probe_cnt = 0;
    secs(12);
    `CHK(probe_cnt, 0)
    bus(1, 12'h000, 32'h00000001, 2'h0);
    probe_cnt = 0;
    secs(25);
    `CHK(probe_cnt, 2)
    `CHK(alarm_cnt, 0)
    alive <= 2'h2;
    // every failure action against a silent device on port 0
    for (int i = 0; i < 4; i++) begin
      al = (i < 2);
      ct = (i == 0 || i == 3);
      bus(1, 12'h008, {31'h0, i != 1}, 2'h0);
      probe_cnt = 0;
      alarm_cnt = 0;
      fall_cnt = 0;
      off_len = 0;
      bus(1, 12'h100, cfgw(1, 2'(i), 3'h1, 10'h00A), 2'h0);
      secs(35);
      // the restart case stays enabled to see probing resume after startup
      if (i != 3) bus(1, 12'h100, cfgw(0, 2'(i), 3'h1, 10'h00A), 2'h0);
      `CHK(probe_cnt, (i == 2) ? 3 : 2)
      secs(40);
      if (i == 3) `CHK(probe_cnt, 3)
      `CHK(alarm_cnt != 0, al)
      `CHK(fall_cnt != 0, ct)
      `CHK(off_len, ct ? 3 * TK : 0)
      `CHK(irq_o, al && i != 1)
      bus(0, 12'h004, {31'h0, al}, 2'h0);
      `CHK(irq_o, 1'b0)
      bus(0, 12'h10C, 32'h00000100, 2'h0);
    end
    // port 1 answers late but in time: no misses, power kept
    bus(0, 12'h11C, 32'h00000100, 2'h0);
    `CHK(power_on_o[1], 1'b1)
    end_of_test;
  end
  // watchdog against a hang
  initial begin
    repeat (60000) @(posedge clk_i);
    bad_count++;
    end_of_test;
  end
endmodule : testbench
`default_nettype wire

/* File: verification/wd_assertions.sv */
// checker: port 0 and bus handshake assertions for the liveness watchdog
`default_nettype none
module wd_assertions #(
  parameter int unsigned PORTS = 8, // supervised ports
  parameter int unsigned TICK_CYCLES = 10 // clocks per second
) (
  input wire logic clk_i, // system clock
  input wire logic rstn_i, // sync reset, active low
  input wire logic s_axi_awvalid, // write address valid
  input wire logic s_axi_awready, // write address ready
  input wire logic s_axi_wvalid, // write data valid
  input wire logic s_axi_wready, // write data ready
  input wire logic s_axi_bvalid, // write response valid
  input wire logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic s_axi_rvalid, // read data valid
  input wire logic [PORTS-1:0] probe_o, // probe pulses
  input wire logic [PORTS-1:0] power_on_o, // port power
  input wire logic [PORTS-1:0] alarm_o // alarm pulses
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] off_cnt, on_cnt, gap_cnt;
  // ==================== port 0 time keeping ====================
  // cycles unpowered, since power return, since last probe
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      off_cnt <= 32'h00000000;
      on_cnt <= 32'hFFFFFFFF;
      gap_cnt <= 32'hFFFFFFFF;
    end else begin
      off_cnt <= power_on_o[0] ? 32'h00000000 : off_cnt + 32'h00000001;
      on_cnt <= !power_on_o[0] ? 32'h00000000 : on_cnt + 32'(on_cnt != 32'hFFFFFFFF);
      gap_cnt <= probe_o[0] ? 32'h00000000 : gap_cnt + 32'(gap_cnt != 32'hFFFFFFFF);
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  // ==================== sequences ====================
  sequence write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence power_back;
    $rose(power_on_o[0]);
  endsequence
  // ==================== assertions ====================
  AST_PROBE_PULSE: assert property (probe_o[0] |=> !probe_o[0])
    else $error("probe pulse too long");
  AST_PROBE_SPACING: assert property (probe_o[0] |-> gap_cnt >= 10 * TICK_CYCLES - 1)
    else $error("probes too close");
  AST_STARTUP_QUIET: assert property (probe_o[0] |-> on_cnt >= 30 * TICK_CYCLES)
    else $error("probe inside startup time");
  AST_NO_PROBE_OFF: assert property (!power_on_o[0] |-> !probe_o[0])
    else $error("probe while unpowered");
  AST_OFF_TIME: assert property (power_back |-> off_cnt >= 3 * TICK_CYCLES && off_cnt <= 120 * TICK_CYCLES)
    else $error("power-off time out of range");
  AST_ALARM_PULSE: assert property (alarm_o[0] |=> !alarm_o[0])
    else $error("alarm pulse too long");
  AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_WRITE_ANSWER: assert property (write_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
endmodule : wd_assertions
bind liveness_watchdog wd_assertions #(.PORTS(PORTS), .TICK_CYCLES(TICK_CYCLES)) chk (
  .clk_i, .rstn_i, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .probe_o, .power_on_o, .alarm_o
);
`default_nettype wire
